// >>> src/iem_consts.svh
`ifndef IEM_CONSTS_SVH
`define IEM_CONSTS_SVH

// Register offsets on the internal data bus
`define IEM_OFF_MASK_TWO   8'h09
`define IEM_OFF_MASK_ONE   8'h2d
`define IEM_OFF_FLAGS_TWO  8'h08

// Reset values
`define IEM_RST_MASK       8'h00
`define IEM_RST_FLAGS      8'h00
`define IEM_RST_RDATA      8'h00
`define IEM_RST_RUN        1'b1
`define IEM_RST_IRQ        1'b0
`define IEM_RST_SYNC       4'hf
`define IEM_RST_LVL_SYNC   2'h3

// Mask one / flag one bit positions
`define IEM_M1_FALL_P5_3   7
`define IEM_M1_FALL_P5_2   6
`define IEM_M1_RISE_P5_1   5
`define IEM_M1_RISE_P5_0   4
`define IEM_M1_FALL_P4_7   3
`define IEM_M1_FALL_P4_6   2
`define IEM_M1_RISE_P4_5   1
`define IEM_M1_RISE_P4_4   0

// Mask two / flag two bit positions
`define IEM_M2_LVL_TWO     7
`define IEM_M2_LVL_ONE     6
`define IEM_M2_TIMER_TWO   5
`define IEM_M2_TIMER_ONE   4
`define IEM_M2_FALL_P5_7   3
`define IEM_M2_RISE_P5_6   2
`define IEM_M2_RISE_P5_5   1
`define IEM_M2_RISE_P5_4   0

// Port five pin index within the edge pin group p5_7..p5_4
`define IEM_PIN_P5_7       3
`define IEM_PIN_P5_6       2
`define IEM_PIN_P5_5       1
`define IEM_PIN_P5_4       0

`endif

// >>> src/iem_pkg.sv
package iem_pkg;
  typedef logic [7:0] iem_byte_t;
  typedef logic [3:0] iem_pins_t;
endpackage : iem_pkg

// >>> src/iem_flags.sv
`timescale 1ns/100ps
`default_nettype none
`include "iem_consts.svh"

module iem_flags
  import iem_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_n_i,
  input  wire iem_pins_t edge_pins_i,
  input  wire logic      level_irq_pin_two_n_i,
  input  wire logic      level_irq_pin_one_n_i,
  input  wire logic      timer_two_edge_i,
  input  wire logic      timer_one_edge_i,
  input  wire iem_byte_t clear_i,
  output var  iem_byte_t int_pending_flags_o
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, third stage only for edge detection
  iem_pins_t pin_s1_r;
  iem_pins_t pin_s2_r;
  iem_pins_t pin_s3_r;
  logic      lvl_two_s1_r;
  logic      lvl_two_s2_r;
  logic      lvl_one_s1_r;
  logic      lvl_one_s2_r;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_s1_r <= `IEM_RST_SYNC;
      pin_s2_r <= `IEM_RST_SYNC;
      pin_s3_r <= `IEM_RST_SYNC;
      {lvl_two_s1_r, lvl_one_s1_r} <= `IEM_RST_LVL_SYNC;
      {lvl_two_s2_r, lvl_one_s2_r} <= `IEM_RST_LVL_SYNC;
    end else begin
      pin_s1_r <= edge_pins_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      lvl_two_s1_r <= level_irq_pin_two_n_i;
      lvl_two_s2_r <= lvl_two_s1_r;
      lvl_one_s1_r <= level_irq_pin_one_n_i;
      lvl_one_s2_r <= lvl_one_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source events in flag two bit order
  wire iem_pins_t rise_w = pin_s2_r & ~pin_s3_r;
  wire iem_pins_t fall_w = ~pin_s2_r & pin_s3_r;
  iem_byte_t      event_w;

  always_comb begin
    event_w                    = '0;
    event_w[`IEM_M2_TIMER_TWO] = timer_two_edge_i;
    event_w[`IEM_M2_TIMER_ONE] = timer_one_edge_i;
    event_w[`IEM_M2_FALL_P5_7] = fall_w[`IEM_PIN_P5_7];
    event_w[`IEM_M2_RISE_P5_6] = rise_w[`IEM_PIN_P5_6];
    event_w[`IEM_M2_RISE_P5_5] = rise_w[`IEM_PIN_P5_5];
    event_w[`IEM_M2_RISE_P5_4] = rise_w[`IEM_PIN_P5_4];
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky edge flags, a set beats a clear in the same cycle
  iem_byte_t flags_nxt;

  always_comb begin
    flags_nxt = (int_pending_flags_o & ~clear_i) | event_w;
    flags_nxt[`IEM_M2_LVL_TWO] = ~lvl_two_s2_r;
    flags_nxt[`IEM_M2_LVL_ONE] = ~lvl_one_s2_r;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      int_pending_flags_o <= `IEM_RST_FLAGS;
    end else begin
      int_pending_flags_o <= flags_nxt;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_fall_p57_flag: assert property ($fell(pin_s2_r[`IEM_PIN_P5_7]) |=> int_pending_flags_o[`IEM_M2_FALL_P5_7])
    else $error("fall on p5_7 did not set its flag");
  chk_set_beats_clear: assert property (timer_one_edge_i && clear_i[`IEM_M2_TIMER_ONE]
                                        |=> int_pending_flags_o[`IEM_M2_TIMER_ONE])
    else $error("timer one event lost against clear");
  chk_clear_drops_flag: assert property (clear_i[`IEM_M2_RISE_P5_4] && !event_w[`IEM_M2_RISE_P5_4]
                                         |=> !int_pending_flags_o[`IEM_M2_RISE_P5_4])
    else $error("flag p5_4 not cleared");
  chk_level_two_flag: assert property (!lvl_two_s2_r |=> int_pending_flags_o[`IEM_M2_LVL_TWO])
    else $error("low level pin two not flagged");
  cov_edge_cleared: cover property (int_pending_flags_o[`IEM_M2_RISE_P5_5] ##1 clear_i[`IEM_M2_RISE_P5_5]);

endmodule : iem_flags
`default_nettype wire

// >>> src/iem_top.sv
// Notes on behaviour
// - A read of either mask register returns its contents on the data bus and a write loads the bus value into it.
// - A mask bit at 1 lets the flag at the same position raise the interrupt and a mask bit at 0 blocks it.
// - If the run pin is low when an enabled interrupt occurs and the wake control bit is 0, the run pin goes high.
// - Mask one bits 7..0 enable falls on p5_3, p5_2, rises on p5_1, p5_0, falls on p4_7, p4_6, rises on p4_5, p4_4.
// - Mask two bit 3 enables the fall on p5_7 and bits 2..0 enable the rises on p5_6, p5_5 and p5_4.
// - Mask two bits 7 and 6 enable low level pins two and one, bits 5 and 4 the timer two and timer one edges.
// - Flag two holds 1 for each source event that occurred and 0 otherwise, with the bit order of mask two.
`timescale 1ns/100ps
`default_nettype none
`include "iem_consts.svh"

module iem_top
  import iem_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire logic      rst_n_i,
  input  wire iem_byte_t bus_addr_i,
  input  wire logic      bus_wr_i,
  input  wire logic      bus_rd_i,
  input  wire iem_byte_t bus_wdata_i,
  input  wire iem_byte_t int_pending_flags_one_i,
  input  wire logic      fall_in_p5_7_i,
  input  wire logic      rise_in_p5_6_i,
  input  wire logic      rise_in_p5_5_i,
  input  wire logic      rise_in_p5_4_i,
  input  wire logic      level_irq_pin_two_n_i,
  input  wire logic      level_irq_pin_one_n_i,
  input  wire logic      timer_two_edge_i,
  input  wire logic      timer_one_edge_i,
  input  wire logic      wake_pin_control_bit_i,
  input  wire logic      run_stop_i,
  output var  iem_byte_t bus_rdata_o,
  output var  iem_byte_t int_pending_flags_two_o,
  output var  logic      irq_o,
  output var  logic      run_o
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic addr_hit(input iem_byte_t addr, input iem_byte_t off);
    addr_hit = (addr == off);
  endfunction : addr_hit

  wire logic hit_mask_one_w  = addr_hit(bus_addr_i, `IEM_OFF_MASK_ONE);
  wire logic hit_mask_two_w  = addr_hit(bus_addr_i, `IEM_OFF_MASK_TWO);
  wire logic hit_flags_two_w = addr_hit(bus_addr_i, `IEM_OFF_FLAGS_TWO);

  wire logic wr_mask_one_w   = bus_wr_i & hit_mask_one_w;
  wire logic wr_mask_two_w   = bus_wr_i & hit_mask_two_w;
  wire logic wr_flags_two_w  = bus_wr_i & hit_flags_two_w;

  ////////////////////////////////////////////////////////////////////////
  // Mask registers
  iem_byte_t mask_one_r;
  iem_byte_t mask_two_r;
  iem_byte_t mask_one_nxt;
  iem_byte_t mask_two_nxt;

  assign mask_one_nxt = wr_mask_one_w ? bus_wdata_i : mask_one_r;
  assign mask_two_nxt = wr_mask_two_w ? bus_wdata_i : mask_two_r;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mask_one_r <= `IEM_RST_MASK;
      mask_two_r <= `IEM_RST_MASK;
    end else begin
      mask_one_r <= mask_one_nxt;
      mask_two_r <= mask_two_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag register two
  iem_pins_t edge_pins_w;
  iem_byte_t flags_clear_w;

  always_comb begin
    edge_pins_w                = '0;
    edge_pins_w[`IEM_PIN_P5_7] = fall_in_p5_7_i;
    edge_pins_w[`IEM_PIN_P5_6] = rise_in_p5_6_i;
    edge_pins_w[`IEM_PIN_P5_5] = rise_in_p5_5_i;
    edge_pins_w[`IEM_PIN_P5_4] = rise_in_p5_4_i;
  end

  // Write one to clear an edge flag
  assign flags_clear_w = wr_flags_two_w ? bus_wdata_i : '0;

  iem_flags u_flags (
    .mclk_i                (mclk_i),
    .rst_n_i               (rst_n_i),
    .edge_pins_i           (edge_pins_w),
    .level_irq_pin_two_n_i (level_irq_pin_two_n_i),
    .level_irq_pin_one_n_i (level_irq_pin_one_n_i),
    .timer_two_edge_i      (timer_two_edge_i),
    .timer_one_edge_i      (timer_one_edge_i),
    .clear_i               (flags_clear_w),
    .int_pending_flags_o   (int_pending_flags_two_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Per-bit gating of flags by masks
  iem_byte_t gated_one_w;
  iem_byte_t gated_two_w;

  // Mask one positions follow flag one; mask two positions follow flag two
  for (genvar gi = 0; gi < 8; gi++) begin : g_gate
    assign gated_one_w[gi] = int_pending_flags_one_i[gi] & mask_one_r[gi];
    assign gated_two_w[gi] = int_pending_flags_two_o[gi] & mask_two_r[gi];
  end

  wire logic pending_w = (|gated_one_w) | (|gated_two_w);

  ////////////////////////////////////////////////////////////////////////
  // Interrupt request and run pin
  logic irq_nxt;
  logic run_nxt;

  assign irq_nxt = pending_w;

  // Wake only when the control bit allows it; a stop request loses to a wake
  assign run_nxt = (!run_o && pending_w && !wake_pin_control_bit_i) ? 1'b1 :
                   run_stop_i ? 1'b0 : run_o;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      irq_o <= `IEM_RST_IRQ;
      run_o <= `IEM_RST_RUN;
    end else begin
      irq_o <= irq_nxt;
      run_o <= run_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, unmapped addresses read as zero
  iem_byte_t rdata_nxt;

  assign rdata_nxt = !bus_rd_i        ? `IEM_RST_RDATA :
                     hit_mask_one_w  ? mask_one_r :
                     hit_mask_two_w  ? mask_two_r :
                     hit_flags_two_w ? int_pending_flags_two_o :
                     `IEM_RST_RDATA;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bus_rdata_o <= `IEM_RST_RDATA;
    end else begin
      bus_rdata_o <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_mask_one_write: assert property (wr_mask_one_w |=> mask_one_r == $past(bus_wdata_i))
    else $error("mask one did not load bus value");
  chk_mask_two_hold: assert property (!wr_mask_two_w |=> mask_two_r == $past(mask_two_r))
    else $error("mask two changed without write");
  chk_mask_two_read: assert property (bus_rd_i && hit_mask_two_w |=> bus_rdata_o == $past(mask_two_r))
    else $error("mask two read returned wrong value");
  chk_unmapped_read: assert property (bus_rd_i && !hit_mask_one_w && !hit_mask_two_w && !hit_flags_two_w
                                      |=> bus_rdata_o == `IEM_RST_RDATA)
    else $error("unmapped read not zero");
  chk_blocked_flags: assert property ((int_pending_flags_one_i & mask_one_r) == '0 &&
                                      (int_pending_flags_two_o & mask_two_r) == '0 |=> !irq_o)
    else $error("interrupt raised by masked flags");
  chk_mask_one_bit7: assert property (int_pending_flags_one_i[`IEM_M1_FALL_P5_3]
                                      && mask_one_r[`IEM_M1_FALL_P5_3] |=> irq_o)
    else $error("p5_3 fall enable did not raise interrupt");
  chk_timer_two_irq: assert property (int_pending_flags_two_o[`IEM_M2_TIMER_TWO]
                                      && mask_two_r[`IEM_M2_TIMER_TWO] |=> irq_o)
    else $error("timer two enable did not raise interrupt");
  chk_irq_follows: assert property (pending_w |=> irq_o)
    else $error("pending enabled flag without interrupt");
  chk_run_wake: assert property (!run_o && pending_w && !wake_pin_control_bit_i |=> run_o)
    else $error("run pin not woken by enabled interrupt");
  chk_run_no_wake: assert property (!run_o && wake_pin_control_bit_i |=> !run_o)
    else $error("run pin woke with control bit set");

  // Register access
  chk_mask_one_hold: assert property (!wr_mask_one_w |=> mask_one_r == $past(mask_one_r))
    else $error("mask one changed without write");
  chk_mask_two_write: assert property (wr_mask_two_w |=> mask_two_r == $past(bus_wdata_i))
    else $error("mask two did not load bus value");
  chk_mask_one_read: assert property (bus_rd_i && hit_mask_one_w |=> bus_rdata_o == $past(mask_one_r))
    else $error("mask one read returned wrong value");
  chk_flags_two_read: assert property (bus_rd_i && hit_flags_two_w
                                       |=> bus_rdata_o == $past(int_pending_flags_two_o))
    else $error("flag two read returned wrong value");
  chk_rdata_idle: assert property (!bus_rd_i |=> bus_rdata_o == `IEM_RST_RDATA)
    else $error("read data not zero without read");

  // Gating per bit
  chk_irq_drops: assert property (!pending_w |=> !irq_o)
    else $error("interrupt held without enabled flag");
  chk_rise_p44_irq: assert property (int_pending_flags_one_i[`IEM_M1_RISE_P4_4]
                                     && mask_one_r[`IEM_M1_RISE_P4_4] |=> irq_o)
    else $error("p4_4 rise enable did not raise interrupt");
  chk_rise_p54_irq: assert property (int_pending_flags_two_o[`IEM_M2_RISE_P5_4]
                                     && mask_two_r[`IEM_M2_RISE_P5_4] |=> irq_o)
    else $error("p5_4 rise enable did not raise interrupt");
  chk_rise_p56_irq: assert property (int_pending_flags_two_o[`IEM_M2_RISE_P5_6]
                                     && mask_two_r[`IEM_M2_RISE_P5_6] |=> irq_o)
    else $error("p5_6 rise enable did not raise interrupt");
  chk_level_two_irq: assert property (int_pending_flags_two_o[`IEM_M2_LVL_TWO]
                                      && mask_two_r[`IEM_M2_LVL_TWO] |=> irq_o)
    else $error("level pin two enable did not raise interrupt");

  // Run pin
  chk_run_stop: assert property (run_stop_i && (run_o || !pending_w || wake_pin_control_bit_i)
                                 |=> !run_o)
    else $error("run pin not stopped on request");
  chk_run_hold: assert property (run_o && !run_stop_i |=> run_o)
    else $error("run pin fell without stop request");

  cov_flag_read: cover property (bus_rd_i && hit_flags_two_w ##1 bus_rdata_o != '0);
  cov_irq_raise: cover property (wr_mask_two_w ##1 !irq_o ##1 irq_o);
  cov_run_wake:  cover property (!run_o ##1 run_o);
  cov_read_one:  cover property (bus_rd_i && hit_mask_one_w ##1 bus_rdata_o != '0);

endmodule : iem_top
`default_nettype wire

// >>> dv/iem_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module iem_core_model
  import iem_pkg::*;
(
  input  wire logic      mclk_i,
  input  wire iem_byte_t bus_rdata_i,
  output var  iem_byte_t bus_addr_o,
  output var  logic      bus_wr_o,
  output var  logic      bus_rd_o,
  output var  iem_byte_t bus_wdata_o
);
  initial begin
    bus_addr_o  = 8'h00;
    bus_wr_o    = 1'b0;
    bus_rd_o    = 1'b0;
    bus_wdata_o = 8'h00;
  end
  // Strobe held over one rising edge
  task automatic wr(input iem_byte_t a, input iem_byte_t d);
    @(negedge mclk_i);
    bus_addr_o  = a;
    bus_wdata_o = d;
    bus_wr_o    = 1'b1;
    @(negedge mclk_i);
    bus_wr_o    = 1'b0;
    // Released lines lose their old value
    bus_addr_o  = ~a;
    bus_wdata_o = ~d;
  endtask : wr
  task automatic rd(input iem_byte_t a, output iem_byte_t d);
    @(negedge mclk_i);
    bus_addr_o = a;
    bus_rd_o   = 1'b1;
    @(negedge mclk_i);
    bus_rd_o   = 1'b0;
    bus_addr_o = ~a;
    d          = bus_rdata_i;
  endtask : rd
endmodule : iem_core_model
`default_nettype wire

// >>> dv/interrupt_enable_masks_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "iem_consts.svh"
module interrupt_enable_masks_tb_top
  import iem_pkg::*;
;
  logic      mclk = 1'b0, rst_n = 1'b0, wake = 1'b0, run_stop = 1'b0;
  logic      irq, run, bwr, brd;
  logic [1:0] tmr = 2'b00, lvl_n = 2'b11;
  iem_pins_t pins = 4'b1000;
  iem_byte_t fl1 = 8'h00, addr, wdata, rdata, fl2, d;
  int        error_cnt = 0, n_compared = 0, cyc = 0;

  always #2 mclk = ~mclk;

  iem_core_model u_iem_core_model (.mclk_i(mclk), .bus_rdata_i(rdata), .bus_addr_o(addr),
    .bus_wr_o(bwr), .bus_rd_o(brd), .bus_wdata_o(wdata));
  iem_top u_iem_top (.mclk_i(mclk), .rst_n_i(rst_n), .bus_addr_i(addr), .bus_wr_i(bwr),
    .bus_rd_i(brd), .bus_wdata_i(wdata), .int_pending_flags_one_i(fl1),
    .fall_in_p5_7_i(pins[3]), .rise_in_p5_6_i(pins[2]), .rise_in_p5_5_i(pins[1]),
    .rise_in_p5_4_i(pins[0]), .level_irq_pin_two_n_i(lvl_n[1]), .level_irq_pin_one_n_i(lvl_n[0]),
    .timer_two_edge_i(tmr[1]), .timer_one_edge_i(tmr[0]), .wake_pin_control_bit_i(wake),
    .run_stop_i(run_stop), .bus_rdata_o(rdata), .int_pending_flags_two_o(fl2), .irq_o(irq),
    .run_o(run));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input iem_byte_t got, input iem_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    u_iem_core_model.rd(`IEM_OFF_MASK_ONE, d);
    chk(d, 8'h00);
    u_iem_core_model.rd(`IEM_OFF_MASK_TWO, d);
    chk(d, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test reset done");

    u_iem_core_model.wr(`IEM_OFF_MASK_ONE, 8'ha5);
    u_iem_core_model.wr(`IEM_OFF_MASK_TWO, 8'h5a);
    u_iem_core_model.rd(`IEM_OFF_MASK_ONE, d);
    chk(d, 8'ha5);
    u_iem_core_model.rd(`IEM_OFF_MASK_TWO, d);
    chk(d, 8'h5a);
    u_iem_core_model.rd(8'h40, d);
    chk(d, 8'h00);
    $display("test register access done");

    for (int i = 0; i < 8; i++) begin
      fl1 = 8'h01 << i;
      u_iem_core_model.wr(`IEM_OFF_MASK_ONE, 8'h01 << i);
      @(negedge mclk);
      chk({7'h0, irq}, 8'h01);
      u_iem_core_model.wr(`IEM_OFF_MASK_ONE, ~(8'h01 << i));
      @(negedge mclk);
      chk({7'h0, irq}, 8'h00);
    end
    fl1 = 8'h00;
    $display("test mask one gating done");

    // Events: pins 0..3, timers 4..5, level pins 6..7
    u_iem_core_model.wr(`IEM_OFF_MASK_TWO, 8'ha5);
    for (int k = 0; k < 8; k++) begin
      if (k < 4)
        pins[k] = ~pins[k];
      else if (k > 5)
        lvl_n[k-6] = 1'b0;
      else
        tmr[k-4] = 1'b1;
      @(negedge mclk);
      tmr = 2'b00;
      repeat (5) @(negedge mclk);
      chk(fl2, 8'h01 << k);
      chk({7'h0, irq}, (8'ha5 >> k) & 8'h01);
      u_iem_core_model.rd(`IEM_OFF_FLAGS_TWO, d);
      chk(d, 8'h01 << k);
      if (k < 4)
        pins[k] = ~pins[k];
      lvl_n = 2'b11;
      repeat (5) @(negedge mclk);
      u_iem_core_model.wr(`IEM_OFF_FLAGS_TWO, 8'h01 << k);
      @(negedge mclk);
      chk(fl2, 8'h00);
      chk({7'h0, irq}, 8'h00);
    end
    // Timer one event in the same cycle as its clear
    fork
      u_iem_core_model.wr(`IEM_OFF_FLAGS_TWO, 8'h10);
      begin
        @(negedge mclk);
        tmr[0] = 1'b1;
        @(negedge mclk);
        tmr[0] = 1'b0;
      end
    join
    chk(fl2, 8'h10);
    u_iem_core_model.wr(`IEM_OFF_FLAGS_TWO, 8'h10);
    @(negedge mclk);
    chk(fl2, 8'h00);
    $display("test flag two events done");

    u_iem_core_model.wr(`IEM_OFF_MASK_TWO, 8'h80);
    wake = 1'b1;
    run_stop = 1'b1;
    @(negedge mclk);
    run_stop = 1'b0;
    chk({7'h0, run}, 8'h00);
    lvl_n[1] = 1'b0;
    repeat (5) @(negedge mclk);
    chk({7'h0, run}, 8'h00);
    wake = 1'b0;
    repeat (2) @(negedge mclk);
    chk({7'h0, run}, 8'h01);
    lvl_n[1] = 1'b1;
    $display("test run pin wake done");

    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
    u_iem_core_model.rd(`IEM_OFF_MASK_ONE, d);
    chk(d, 8'h00);
    u_iem_core_model.rd(`IEM_OFF_MASK_TWO, d);
    chk(d, 8'h00);
    chk({7'h0, irq}, 8'h00);
    $display("test mid-run reset done");
    results;
  end
endmodule : interrupt_enable_masks_tb_top
`default_nettype wire
